// >>> core/deser_cfg_params.svh
// Offsets, field positions, reset values and timing counts of the configuration bank
`ifndef DESER_CFG_PARAMS_SVH
`define DESER_CFG_PARAMS_SVH
`define OFS_ADDR_OVR 8'h00
`define OFS_PWR_RST 8'h01
`define OFS_OUT_CFG 8'h02
`define RST_ADDR_OVR 8'h00
`define RST_PWR_RST 8'h04
`define RST_OUT_CFG 8'h00
`define BIT_ADDR_SEL 0
`define BIT_AUTO_PD 7
`define BIT_BC_EN 2
`define BIT_FULL_RST 1
`define BIT_DP_RST 0
`define BIT_OE 7
`define BIT_PIN_OVR 6
`define BIT_OSC_EN 5
`define BIT_OSS 4
`define BIT_BCM_OVR 3
`define BIT_BCM 2
`define BIT_LF_OVR 1
`define BIT_LF 0
`define STRAP_ADDR_BASE 7'h2C
`define MODE_BC_INDEX 4'h8
`define CLK_PERIOD_NS 100
`define SOFT_RST_NS 400
`define SOFT_RST_CYC (((`SOFT_RST_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`endif

// >>> core/deser_cfg_pkg.sv
// State type of the serial bus slave that serves the configuration bank
package deser_cfg_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_WRITE = 3'b011,
    ST_READ = 3'b100,
    ST_RACK = 3'b101
  } bus_state_t;
endpackage

// >>> core/cfg_bus_slave.sv
// Two-wire serial bus slave with register pointer, byte writes and byte reads
`timescale 1ns/10ps
module cfg_bus_slave
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe,
  // Target address and register port
  input wire logic [6:0] dev_addr,
  output logic [7:0] reg_ptr,
  input wire logic [7:0] rd_data,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  deser_cfg_pkg::bus_state_t state_q;
  logic scl_q, sda_q, rw_q, have_ptr_q, sda_oe_q, wr_stb_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, ptr_q, wr_addr_q;
  logic scl_rise, scl_fall, start_c, stop_c, addr_hit, byte_end;

  // Edge, start and stop decode from the sampled lines
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_c = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
  assign addr_hit = (shift_q[7:1] == dev_addr);
  assign byte_end = (cnt_q == 4'h8);
  assign sda_oe = sda_oe_q;
  assign reg_ptr = ptr_q;
  assign wr_stb = wr_stb_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = shift_q;

  // Protocol sequencer; the line is only ever pulled low or released
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= deser_cfg_pkg::ST_IDLE;
      {scl_q, sda_q, rw_q, have_ptr_q, sda_oe_q, wr_stb_q} <= 6'h3C;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_stb_q <= 1'b0;
      if (start_c)
      begin
        state_q <= deser_cfg_pkg::ST_ADDR;
        cnt_q <= 4'h0;
        have_ptr_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end
      else if (stop_c)
      begin
        state_q <= deser_cfg_pkg::ST_IDLE;
        sda_oe_q <= 1'b0;
      end
      else
        case (state_q)
          deser_cfg_pkg::ST_ADDR, deser_cfg_pkg::ST_WRITE:
            if (scl_rise)
            begin
              shift_q <= {shift_q[6:0], sda_i};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (scl_fall && byte_end)
            begin
              cnt_q <= 4'h0;
              if (state_q == deser_cfg_pkg::ST_WRITE)
              begin
                sda_oe_q <= 1'b1;
                state_q <= deser_cfg_pkg::ST_ACK;
                have_ptr_q <= 1'b1;
                if (have_ptr_q)
                begin
                  wr_stb_q <= 1'b1;
                  wr_addr_q <= ptr_q;
                  ptr_q <= ptr_q + 8'h01;
                end
                else
                  ptr_q <= shift_q;
              end
              else if (addr_hit)
              begin
                sda_oe_q <= 1'b1;
                rw_q <= shift_q[0];
                state_q <= deser_cfg_pkg::ST_ACK;
              end
              else
                state_q <= deser_cfg_pkg::ST_IDLE;
            end
          deser_cfg_pkg::ST_ACK:
            if (scl_fall)
            begin
              cnt_q <= 4'h0;
              if (rw_q)
              begin
                state_q <= deser_cfg_pkg::ST_READ;
                shift_q <= {rd_data[6:0], 1'b0};
                sda_oe_q <= ~rd_data[7];
                ptr_q <= ptr_q + 8'h01;
              end
              else
              begin
                sda_oe_q <= 1'b0;
                state_q <= deser_cfg_pkg::ST_WRITE;
              end
            end
          deser_cfg_pkg::ST_READ:
            if (scl_rise)
              cnt_q <= cnt_q + 4'h1;
            else if (scl_fall && byte_end)
            begin
              sda_oe_q <= 1'b0;
              state_q <= deser_cfg_pkg::ST_RACK;
            end
            else if (scl_fall)
            begin
              sda_oe_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
            end
          deser_cfg_pkg::ST_RACK:
            if (scl_rise)
              state_q <= sda_i ? deser_cfg_pkg::ST_IDLE : deser_cfg_pkg::ST_ACK;
          default:
            state_q <= deser_cfg_pkg::ST_IDLE;
        endcase
    end
  end

  // The line is released right after a stop and driven only in ack or read
  AST_RELEASE_ON_STOP: assert property (@(posedge clk) disable iff (!rst_n)
    stop_c |=> !sda_oe_q)
    else $error("data line still pulled after stop");
  AST_DRIVE_ONLY_OWN: assert property (@(posedge clk) disable iff (!rst_n)
    sda_oe_q |-> (state_q == deser_cfg_pkg::ST_ACK || state_q == deser_cfg_pkg::ST_READ))
    else $error("data line pulled outside ack or read");
endmodule // cfg_bus_slave

// >>> core/deser_cfg_bank.sv
// Configuration front end: target address, power and soft reset control, output config
//
// Behaviour
// - Answer at one of sixteen selectable addresses
// - Strap index picks address 0x2C upward to 0x3B
// - Bus lines only pulled low or released
// - Register address bits override strap when enabled
// - Auto power-down while forward link absent
// - Back channel enable bit, on after reset
// - Full reset bit resets registers, self-clears
// - Datapath reset bit keeps registers, self-clears
// - Output enable bit, off after reset; outputs follow pin until override set
// - Override bit hands pin controls to register
// - Oscillator clock on pixel clock when unlocked
// - Sleep state select governs outputs while unlocked
// - Backward mode from register or mode strap
// - Low frequency mode from register or strap
// - Low frequency bit selects pixel clock range
// - Mode strap decodes four mode flags
`timescale 1ns/10ps
`include "deser_cfg_params.svh"
module deser_cfg_bank
#(
  parameter int unsigned RST_CYCLES = `SOFT_RST_CYC
)
(
  // Clock and power-down reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Serial configuration bus, open drain
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // Straps and control pins
  input wire logic [3:0] ADDRESS_STRAP_PIN,
  input wire logic [3:0] MODE_STRAP_PIN,
  input wire logic OUTPUT_ENABLE_PIN,
  input wire logic OUTPUT_SLEEP_STATE_SELECT_PIN,
  input wire logic LINK_DETECT,
  input wire logic LOCK,
  // Resulting configuration
  output logic [6:0] TARGET_ADDR,
  output logic POWER_DOWN,
  output logic BACK_CHANNEL_ENABLE,
  output logic OUTPUT_ENABLE,
  output logic OUTPUT_SLEEP_STATE_SELECT,
  output logic OSC_ON_PCLK,
  output logic BACKWARD_COMPAT_MODE,
  output logic LOW_FREQUENCY_MODE,
  output logic REPEATER_MODE,
  output logic AUDIO_CHANNEL_B_MODE,
  output logic DATAPATH_RESET_N
);
  localparam int CW = $clog2(RST_CYCLES + 1);
  localparam logic [7:0] PWR_RST_VAL = `RST_PWR_RST;

  logic [7:0] addr_ovr_q, cfg_q;
  logic auto_pd_q, bc_en_q, strap_done_q;
  logic [3:0] strap_addr_q, strap_mode_q;
  logic [CW-1:0] full_cnt_q, dp_cnt_q;
  logic [7:0] reg_ptr, rd_data, wr_addr, wr_data, pwr_rd;
  logic wr_stb, sda_oe_c;

  // Bus slave; the clock line is never stretched
  cfg_bus_slave u_slave
  (
    .clk(CLOCK),
    .rst_n(RESETN),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .sda_oe(sda_oe_c),
    .dev_addr(TARGET_ADDR),
    .reg_ptr(reg_ptr),
    .rd_data(rd_data),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // Open-drain lines only ever pull low
  assign SCL_O = 1'b0;
  assign SCL_OE = 1'b0;
  assign SDA_O = 1'b0;
  assign SDA_OE = sda_oe_c;

  // Write decode; writes are ignored while a full reset runs
  logic full_busy, dp_busy, wr_ok, wr_ovr, wr_pwr, wr_cfg, start_full, start_dp;
  assign full_busy = (full_cnt_q != '0);
  assign dp_busy = (dp_cnt_q != '0);
  assign wr_ok = wr_stb & ~full_busy;
  assign wr_ovr = wr_ok & (wr_addr == `OFS_ADDR_OVR);
  assign wr_pwr = wr_ok & (wr_addr == `OFS_PWR_RST);
  assign wr_cfg = wr_ok & (wr_addr == `OFS_OUT_CFG);
  assign start_full = wr_pwr & wr_data[`BIT_FULL_RST];
  assign start_dp = wr_pwr & wr_data[`BIT_DP_RST];

  // Read mux; reserved bits zero, reset bits show only while running
  assign pwr_rd = {auto_pd_q, 4'h0, bc_en_q, full_busy, dp_busy};
  assign rd_data = (reg_ptr == `OFS_ADDR_OVR) ? addr_ovr_q :
                   (reg_ptr == `OFS_PWR_RST) ? pwr_rd :
                   (reg_ptr == `OFS_OUT_CFG) ? cfg_q : 8'h00;

  // Mode strap decode: indices 0-7 walk three flags, index 8 is backward mode
  logic mode_lo, mode_lf, mode_rep, mode_i2sb, mode_bc;
  assign mode_lo = ~strap_mode_q[3];
  assign mode_lf = mode_lo & strap_mode_q[2];
  assign mode_rep = mode_lo & strap_mode_q[1];
  assign mode_i2sb = mode_lo & strap_mode_q[0];
  assign mode_bc = (strap_mode_q == `MODE_BC_INDEX);

  // Address and effective mode selection
  logic [6:0] strap_addr, target_d;
  logic pin_ovr, oe_d, oss_d, bcm_d, lf_d;
  assign strap_addr = `STRAP_ADDR_BASE + {3'b000, strap_addr_q};
  assign target_d = addr_ovr_q[`BIT_ADDR_SEL] ? addr_ovr_q[7:1] : strap_addr;
  assign pin_ovr = cfg_q[`BIT_PIN_OVR];
  assign oe_d = pin_ovr ? cfg_q[`BIT_OE] : OUTPUT_ENABLE_PIN;
  assign oss_d = pin_ovr ? cfg_q[`BIT_OSS] : OUTPUT_SLEEP_STATE_SELECT_PIN;
  assign bcm_d = cfg_q[`BIT_BCM_OVR] ? cfg_q[`BIT_BCM] : mode_bc;
  assign lf_d = cfg_q[`BIT_LF_OVR] ? cfg_q[`BIT_LF] : mode_lf;

  // Straps are caught once after power-down release, so mode changes need one
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      strap_done_q <= 1'b0;
      strap_addr_q <= 4'h0;
      strap_mode_q <= 4'h0;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      strap_addr_q <= ADDRESS_STRAP_PIN;
      strap_mode_q <= MODE_STRAP_PIN;
    end
  end

  // Software registers; a running full reset holds them at reset values
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      addr_ovr_q <= `RST_ADDR_OVR;
      {auto_pd_q, bc_en_q} <= {PWR_RST_VAL[`BIT_AUTO_PD], PWR_RST_VAL[`BIT_BC_EN]};
      cfg_q <= `RST_OUT_CFG;
    end
    else if (full_busy)
    begin
      addr_ovr_q <= `RST_ADDR_OVR;
      {auto_pd_q, bc_en_q} <= {PWR_RST_VAL[`BIT_AUTO_PD], PWR_RST_VAL[`BIT_BC_EN]};
      cfg_q <= `RST_OUT_CFG;
    end
    else
    begin
      if (wr_ovr)
        addr_ovr_q <= wr_data;
      if (wr_pwr)
      begin
        auto_pd_q <= wr_data[`BIT_AUTO_PD];
        bc_en_q <= wr_data[`BIT_BC_EN];
      end
      if (wr_cfg)
        cfg_q <= wr_data;
    end
  end

  // Self-clearing reset timers
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      full_cnt_q <= '0;
      dp_cnt_q <= '0;
    end
    else
    begin
      if (start_full)
        full_cnt_q <= CW'(RST_CYCLES);
      else if (full_busy)
        full_cnt_q <= full_cnt_q - CW'(1);
      if (start_dp)
        dp_cnt_q <= CW'(RST_CYCLES);
      else if (dp_busy)
        dp_cnt_q <= dp_cnt_q - CW'(1);
    end
  end

  // Registered configuration outputs
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TARGET_ADDR <= `STRAP_ADDR_BASE;
      POWER_DOWN <= 1'b0;
      BACK_CHANNEL_ENABLE <= PWR_RST_VAL[`BIT_BC_EN];
      OUTPUT_ENABLE <= 1'b0;
      OUTPUT_SLEEP_STATE_SELECT <= 1'b0;
      OSC_ON_PCLK <= 1'b0;
      BACKWARD_COMPAT_MODE <= 1'b0;
      LOW_FREQUENCY_MODE <= 1'b0;
      REPEATER_MODE <= 1'b0;
      AUDIO_CHANNEL_B_MODE <= 1'b0;
      DATAPATH_RESET_N <= 1'b0;
    end
    else
    begin
      TARGET_ADDR <= target_d;
      POWER_DOWN <= auto_pd_q & ~LINK_DETECT;
      BACK_CHANNEL_ENABLE <= bc_en_q;
      OUTPUT_ENABLE <= oe_d;
      OUTPUT_SLEEP_STATE_SELECT <= oss_d;
      OSC_ON_PCLK <= cfg_q[`BIT_OSC_EN] & ~LOCK;
      BACKWARD_COMPAT_MODE <= bcm_d;
      LOW_FREQUENCY_MODE <= lf_d; // High means 5 to under 15 MHz
      REPEATER_MODE <= mode_rep;
      AUDIO_CHANNEL_B_MODE <= mode_i2sb;
      DATAPATH_RESET_N <= ~(full_busy | dp_busy);
    end
  end

  // Checks on the configuration behaviour
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  sequence full_run_s;
    full_busy [*4];
  endsequence
  sequence full_done_s;
    !full_busy && cfg_q == `RST_OUT_CFG && bc_en_q && !auto_pd_q;
  endsequence
  sequence dp_low_s;
    !DATAPATH_RESET_N [*4];
  endsequence

  AST_ADDR_STRAP: assert property (
    strap_done_q && !addr_ovr_q[0] |=>
      TARGET_ADDR == `STRAP_ADDR_BASE + {3'b000, $past(strap_addr_q)})
    else $error("strapped address wrong");
  AST_ADDR_OVR: assert property (
    addr_ovr_q[0] |=> TARGET_ADDR == $past(addr_ovr_q[7:1]))
    else $error("override address not applied");
  AST_AUTO_PD: assert property (
    auto_pd_q && !LINK_DETECT |=> POWER_DOWN)
    else $error("no power-down without link");
  AST_NO_PD: assert property (
    !auto_pd_q |=> !POWER_DOWN)
    else $error("power-down while disabled");
  AST_BC_EN: assert property (
    wr_pwr && !start_full |=> ##1 BACK_CHANNEL_ENABLE == $past(wr_data[2], 2))
    else $error("back channel enable not following write");
  AST_FULL_RST: assert property (
    start_full |=> full_run_s ##1 full_done_s)
    else $error("full reset sequence wrong");
  AST_DP_RST: assert property (
    start_dp && !start_full |=> ##1 dp_low_s ##1 DATAPATH_RESET_N)
    else $error("datapath reset pulse wrong");
  AST_DP_KEEP: assert property (
    start_dp && !start_full |=> $stable(cfg_q) && $stable(addr_ovr_q))
    else $error("datapath reset touched registers");
  AST_OE_REG: assert property (
    pin_ovr |=> OUTPUT_ENABLE == $past(cfg_q[7]))
    else $error("register output enable ignored");
  AST_OE_PIN: assert property (
    strap_done_q && !pin_ovr |=> OUTPUT_ENABLE == $past(OUTPUT_ENABLE_PIN))
    else $error("output enable pin ignored");
  AST_OSC: assert property (
    cfg_q[5] && !LOCK |=> OSC_ON_PCLK)
    else $error("oscillator not routed on lock loss");
  AST_OSC_OFF: assert property (
    LOCK |=> !OSC_ON_PCLK)
    else $error("oscillator routed while locked");
  AST_BCM: assert property (
    cfg_q[3] |=> BACKWARD_COMPAT_MODE == $past(cfg_q[2]))
    else $error("backward mode override ignored");
  AST_LF_PIN: assert property (
    !cfg_q[1] |=> LOW_FREQUENCY_MODE == $past(mode_lf))
    else $error("low frequency strap ignored");
  AST_RSVD: assert property (
    reg_ptr == `OFS_PWR_RST && !full_busy && !dp_busy |-> rd_data[6:0] == {4'h0, bc_en_q, 2'b00})
    else $error("reserved or reset bits not zero");
  AST_OSS_REG: assert property (
    pin_ovr |=> OUTPUT_SLEEP_STATE_SELECT == $past(cfg_q[4]))
    else $error("register sleep state select ignored");
  AST_OSS_PIN: assert property (
    strap_done_q && !pin_ovr |=>
      OUTPUT_SLEEP_STATE_SELECT == $past(OUTPUT_SLEEP_STATE_SELECT_PIN))
    else $error("sleep state select pin ignored");
  AST_BCM_PIN: assert property (
    !cfg_q[3] |=> BACKWARD_COMPAT_MODE == $past(mode_bc))
    else $error("backward mode strap ignored");
  AST_LF_REG: assert property (
    cfg_q[1] |=> LOW_FREQUENCY_MODE == $past(cfg_q[0]))
    else $error("low frequency override ignored");
  AST_FULL_HOLD: assert property (
    full_busy |=> addr_ovr_q == `RST_ADDR_OVR && cfg_q == `RST_OUT_CFG)
    else $error("registers not held during full reset");
endmodule // deser_cfg_bank

// >>> test/i2c_host_model.sv
// Two-wire bus host model: releases or pulls its lines, pull-ups make the high level
`timescale 1ns/10ps
module i2c_host_model
(
  // Clock
  input wire logic clk,
  // Resolved data line, line releases (high = released)
  input wire logic sda_line,
  output logic scl_rel,
  output logic sda_rel
);
  // Idle bus, clock stands still high outside frames
  initial
  begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  // Start or repeated start, data falls while clock high
  task automatic start_cond();
    sda_rel <= 1'b1;
    @(posedge clk);
    scl_rel <= 1'b1;
    repeat (2) @(posedge clk);
    sda_rel <= 1'b0;
    repeat (2) @(posedge clk);
    scl_rel <= 1'b0;
    @(posedge clk);
  endtask
  // Stop, data rises while clock high
  task automatic stop_cond();
    sda_rel <= 1'b0;
    @(posedge clk);
    scl_rel <= 1'b1;
    repeat (2) @(posedge clk);
    sda_rel <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // Eight bits MSB first plus acknowledge slot, data changes only with clock low
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_rel <= tx[i];
      @(posedge clk);
      scl_rel <= 1'b1;
      repeat (2) @(posedge clk);
      rx[i] = sda_line;
      scl_rel <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Register write: address, pointer, data; nak reports a refused address
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                           output logic nak);
    logic [8:0] rx;
    start_cond();
    xfer({a, 2'b01}, rx);
    nak = rx[0];
    xfer({p, 1'b1}, rx);
    xfer({d, 1'b1}, rx);
    stop_cond();
  endtask
  // Register read through repeated start, last byte not acknowledged
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                          output logic nak);
    logic [8:0] rx;
    start_cond();
    xfer({a, 2'b01}, rx);
    nak = rx[0];
    xfer({p, 1'b1}, rx);
    start_cond();
    xfer({a, 2'b11}, rx);
    xfer(9'h1FF, rx);
    d = rx[8:1];
    stop_cond();
  endtask
endmodule // i2c_host_model

// >>> test/testbench.sv
// Self-checking bench for the deserializer configuration bank
`timescale 1ns/10ps
module testbench;
  localparam int rst_cyc = 4;
  localparam logic [7:0] tbl [8] = '{8'h00, 8'h40, 8'hD0, 8'h20, 8'h08, 8'h0C, 8'h02, 8'h03};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] addr_strap = 4'h0;
  logic [3:0] mode_strap = 4'h0;
  logic oe_pin = 1'b0;
  logic oss_pin = 1'b0;
  logic link = 1'b1;
  logic lock = 1'b1;
  logic scl_rel, sda_rel, scl_o, scl_oe, sda_o, sda_oe;
  logic [6:0] tgt;
  logic pd, bce, oe, oss, osc, bcm, lf, rep, aud, dp_n, nak;
  logic [7:0] rd;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int dp_low = 0;
  // Open-drain wires with pull-ups
  wire scl_line = scl_rel & ~(scl_oe & ~scl_o);
  wire sda_line = sda_rel & ~(sda_oe & ~sda_o);
  // Clock
  always #50 clock = ~clock;
  // Design and bus host
  deser_cfg_bank #(.RST_CYCLES(rst_cyc)) dut
  (
    .CLOCK(clock), .RESETN(resetn), .SCL_I(scl_line), .SCL_O(scl_o), .SCL_OE(scl_oe),
    .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDRESS_STRAP_PIN(addr_strap),
    .MODE_STRAP_PIN(mode_strap), .OUTPUT_ENABLE_PIN(oe_pin),
    .OUTPUT_SLEEP_STATE_SELECT_PIN(oss_pin), .LINK_DETECT(link), .LOCK(lock),
    .TARGET_ADDR(tgt), .POWER_DOWN(pd), .BACK_CHANNEL_ENABLE(bce), .OUTPUT_ENABLE(oe),
    .OUTPUT_SLEEP_STATE_SELECT(oss), .OSC_ON_PCLK(osc), .BACKWARD_COMPAT_MODE(bcm),
    .LOW_FREQUENCY_MODE(lf), .REPEATER_MODE(rep), .AUDIO_CHANNEL_B_MODE(aud),
    .DATAPATH_RESET_N(dp_n)
  );
  i2c_host_model host (.clk(clock), .sda_line(sda_line), .scl_rel(scl_rel), .sda_rel(sda_rel));
  // Datapath reset length monitor and hang limit
  always @(posedge clock)
  begin
    if (resetn === 1'b1 && dp_n === 1'b0)
      dp_low++;
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      close_out();
    end
  end
  // Compare bytes
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compare flags
  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  // Power-down pin pulse
  task automatic pin_reset();
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  // Values after reset
  task automatic t_defaults();
    chk({1'b0, tgt}, 8'h2C);
    chk_bit(bce, 1'b1);
    chk({4'h0, scl_oe, scl_o, sda_o, sda_oe}, 8'h00);
    host.read_reg(7'h2C, 8'h00, rd, nak);
    chk(rd, 8'h00);
    host.read_reg(7'h2C, 8'h01, rd, nak);
    chk(rd, 8'h04);
    host.read_reg(7'h2C, 8'h02, rd, nak);
    chk(rd, 8'h00);
  endtask
  // Every address and mode strap, each answered at the strapped address; 0x2C refused under strap 15
  task automatic t_straps();
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clock);
      addr_strap <= i[3:0];
      mode_strap <= i[3:0];
      pin_reset();
      chk({1'b0, tgt}, 8'h2C + i[7:0]);
      chk({4'h0, lf, rep, bcm, aud}, i < 8 ? {4'h0, i[2:1], 1'b0, i[0]} :
          (i == 8 ? 8'h02 : 8'h00));
      host.read_reg(7'h2C + i[6:0], 8'h01, rd, nak);
      chk_bit(nak, 1'b0);
      chk(rd, 8'h04);
    end
    host.read_reg(7'h2C, 8'h01, rd, nak);
    chk_bit(nak, 1'b1);
  endtask
  // Register address override and its release
  task automatic t_override();
    host.write_reg(7'h3B, 8'h00, 8'h2B, nak);
    chk({1'b0, tgt}, 8'h15);
    host.read_reg(7'h15, 8'h00, rd, nak);
    chk(rd, 8'h2B);
    host.write_reg(7'h15, 8'h00, 8'h2A, nak);
    chk({1'b0, tgt}, 8'h3B);
  endtask
  // Auto power-down, back channel and reserved bits
  task automatic t_power();
    host.write_reg(7'h3B, 8'h01, 8'h84, nak);
    @(posedge clock);
    link <= 1'b0;
    repeat (3) @(posedge clock);
    chk_bit(pd, 1'b1);
    link <= 1'b1;
    repeat (3) @(posedge clock);
    chk_bit(pd, 1'b0);
    host.write_reg(7'h3B, 8'h01, 8'h78, nak);
    link <= 1'b0;
    chk_bit(bce, 1'b0);
    host.read_reg(7'h3B, 8'h01, rd, nak);
    chk(rd, 8'h00);
    chk_bit(pd, 1'b0);
    host.write_reg(7'h3B, 8'h01, 8'h04, nak);
    link <= 1'b1;
    chk_bit(bce, 1'b1);
  endtask
  // Output and mode bits against pins and mode strap (row with backward mode high)
  task automatic t_output();
    logic [7:0] r;
    @(posedge clock);
    mode_strap <= 4'h8;
    pin_reset();
    for (int p = 0; p < 2; p++)
      foreach (tbl[j])
      begin
        @(posedge clock);
        oe_pin <= p[0];
        oss_pin <= p[0];
        lock <= p[0];
        r = tbl[j];
        host.write_reg(7'h3B, 8'h02, r, nak);
        chk({3'h0, oe, oss, osc, bcm, lf}, {3'h0, r[6] ? r[7] : p[0], r[6] ? r[4] : p[0],
            r[5] & ~p[0], r[3] ? r[2] : 1'b1, r[1] & r[0]});
      end
    chk_bit(lf, 1'b1);
    pin_reset();
    chk_bit(lf, 1'b0);
  endtask
  // Datapath reset keeps registers, full reset clears them, both self-clear
  task automatic t_soft();
    host.write_reg(7'h3B, 8'h02, 8'hC0, nak);
    dp_low = 0;
    host.write_reg(7'h3B, 8'h01, 8'h05, nak);
    repeat (4) @(posedge clock);
    chk(8'(dp_low), 8'(rst_cyc));
    host.read_reg(7'h3B, 8'h02, rd, nak);
    chk(rd, 8'hC0);
    dp_low = 0;
    host.write_reg(7'h3B, 8'h01, 8'h06, nak);
    repeat (4) @(posedge clock);
    chk(8'(dp_low), 8'(rst_cyc));
    host.read_reg(7'h3B, 8'h02, rd, nak);
    chk(rd, 8'h00);
    host.read_reg(7'h3B, 8'h01, rd, nak);
    chk(rd, 8'h04);
  endtask
  // Counts and verdict
  task automatic close_out();
    $display("Checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    t_defaults();
    t_straps();
    t_override();
    t_power();
    t_output();
    t_soft();
    close_out();
  end
endmodule // testbench
